// *** orsb_scoreboard.sv ***
// Operation
// - a pending source delays only that unit's start; issue goes on
// - a result awaiting an earlier read delays only its store
// - both operands read together once all source reservations resolve
// - unit or result register conflict in second stage blocks all issue pulses
// - first-to-second stage transfer sets unit request decoded from opcode
// - issue sets unit busy; cleared when the instruction completes
// - requested unit busy disables issue until busy clears
// - result group flags Xi, Bi, Ai, Bj pick register with i or j
// - 24-slot result list gets the producing unit code at issue
// - codes: units 01-07, memory channels 11-15, long add 16, add 17
// - zero slot free, non-zero reserved; reserved result blocks issue
// - memory reads into X1-X5 reserve with a memory channel code
// - source select flags Xj, Bj, Aj, Bk, Xk combine with j or k
// - per-unit 4-bit pending codes loaded from source slots at issue
// - read flag sets at once when its pending code is zero
// - non-zero pending code sets read flag on that unit's release
// - both read flags set sends the unit its go signal
// - go carries a read command with the stored source numbers
// - per-unit 5-bit result and source register indices loaded at issue
// - both read flags clear the cycle after both became set
// - release only when store request meets third-order all clear
// - third-order conflict: set read flag on the storing unit's result register
// - release clears slot and busy, and wakes waiting pending codes
`timescale 1ns/1ps
`default_nettype none
`include "orsb_consts.svh"

module orsb_scoreboard (
  input  wire logic              i_clk,          // 200 MHz minor cycle clock
  input  wire logic              i_sys_rst,      // async reset, active high
  // apb slave
  input  wire logic              i_psel,         // apb select
  input  wire logic              i_penable,      // apb enable
  input  wire logic              i_pwrite,       // apb direction
  input  wire logic [11:0]       i_paddr,        // apb byte address
  input  wire logic [31:0]       i_pwdata,       // apb write data
  output logic                   o_pready,       // apb ready
  output logic      [31:0]       o_prdata,       // apb read data
  output logic                   o_pslverr,      // apb error, unmapped
  // instruction issue
  input  wire logic              i_u1_xfer,      // first to second stage move
  input  wire logic [5:0]        i_u1_opcode,    // operation code
  input  wire orsb_pkg::orsb_num_t i_u1_i,       // i octal
  input  wire orsb_pkg::orsb_num_t i_u1_j,       // j octal
  input  wire orsb_pkg::orsb_num_t i_u1_k,       // k octal
  input  wire logic [3:0]        i_u1_res_sel,   // result group flags
  input  wire logic [4:0]        i_u1_src_sel,   // source select flags
  output logic                   o_u2_free,      // second stage can take
  output logic                   o_issue,        // issue pulse
  // functional units, indexed by code
  input  wire orsb_pkg::orsb_uvec_t i_release_req, // request release
  output orsb_pkg::orsb_uvec_t   o_go,           // start timing chain
  output orsb_pkg::orsb_uvec_t   o_read_j_en,    // read command, j operand
  output orsb_pkg::orsb_uvec_t   o_read_k_en,    // read command, k operand
  output orsb_pkg::orsb_uidx_t   o_read_j_idx,   // j register to exit control
  output orsb_pkg::orsb_uidx_t   o_read_k_idx,   // k register to exit control
  output orsb_pkg::orsb_uvec_t   o_release,      // release, transmit result
  output logic                   o_store_en,     // go store
  output orsb_pkg::orsb_ridx_t   o_store_idx     // result register to entry control
);
  import orsb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // state
  logic                   ctrl_en_reg;
  orsb_ridx_t             slot_sel_reg;
  logic                   u2_valid_reg;
  orsb_code_t             u2_unit_reg;
  orsb_num_t              u2_mem_reg;
  orsb_num_t              u2_i_reg;
  orsb_num_t              u2_j_reg;
  orsb_num_t              u2_k_reg;
  logic [3:0]             u2_res_sel_reg;
  logic [4:0]             u2_src_sel_reg;
  orsb_uvec_t             busy_reg;
  orsb_code_t             result_reservation_list [`ORSB_NUM_REGS];
  orsb_code_t             first_source_pending_code  [`ORSB_NUM_CODES];
  orsb_code_t             second_source_pending_code [`ORSB_NUM_CODES];
  orsb_ridx_t             result_register_number        [`ORSB_NUM_CODES];
  orsb_ridx_t             first_source_register_number  [`ORSB_NUM_CODES];
  orsb_ridx_t             second_source_register_number [`ORSB_NUM_CODES];
  orsb_uvec_t             fi_use_reg;
  orsb_uvec_t             fj_use_reg;
  orsb_uvec_t             fk_use_reg;
  orsb_uvec_t             armed_reg;
  orsb_uvec_t             rfj_reg;
  orsb_uvec_t             rfk_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // second stage decode
  // pairs: pick the second unit only when the first is taken and it is free
  function automatic orsb_code_t decode_unit(input logic [5:0] op, input orsb_uvec_t busy);
    orsb_code_t c;
    c = `ORSB_CODE_NONE;
    unique case (op[5:3])
      3'h1: c = `ORSB_CODE_BOOL;
      3'h2: c = `ORSB_CODE_SHIFT;
      3'h3: c = (op[2:1] == 2'h3) ? `ORSB_CODE_LADD : `ORSB_CODE_ADD;
      3'h4: begin
        if (op[2])
          c = `ORSB_CODE_DIV;
        else
          c = (busy[`ORSB_CODE_MUL1] && !busy[`ORSB_CODE_MUL2]) ? `ORSB_CODE_MUL2 : `ORSB_CODE_MUL1;
      end
      3'h5, 3'h6, 3'h7:
        c = (busy[`ORSB_CODE_INC1] && !busy[`ORSB_CODE_INC2]) ? `ORSB_CODE_INC2 : `ORSB_CODE_INC1;
      default: c = `ORSB_CODE_NONE;
    endcase
    return c;
  endfunction

  logic       has_res;
  logic       has_j;
  logic       has_k;
  logic       mem_use;
  orsb_ridx_t res_idx;
  orsb_ridx_t srcj_idx;
  orsb_ridx_t srck_idx;
  orsb_ridx_t mem_idx;
  orsb_code_t mem_code;

  always_comb begin
    res_idx = {`ORSB_GRP_X, u2_i_reg};
    if (u2_res_sel_reg[`ORSB_RES_BI])
      res_idx = {`ORSB_GRP_B, u2_i_reg};
    else if (u2_res_sel_reg[`ORSB_RES_AI])
      res_idx = {`ORSB_GRP_A, u2_i_reg};
    else if (u2_res_sel_reg[`ORSB_RES_BJ])
      res_idx = {`ORSB_GRP_B, u2_j_reg};
    srcj_idx = {`ORSB_GRP_X, u2_j_reg};
    if (u2_src_sel_reg[`ORSB_SRC_BJ])
      srcj_idx = {`ORSB_GRP_B, u2_j_reg};
    else if (u2_src_sel_reg[`ORSB_SRC_AJ])
      srcj_idx = {`ORSB_GRP_A, u2_j_reg};
    srck_idx = u2_src_sel_reg[`ORSB_SRC_BK] ? {`ORSB_GRP_B, u2_k_reg} : {`ORSB_GRP_X, u2_k_reg};
  end

  assign has_res  = |u2_res_sel_reg;
  assign has_j    = |u2_src_sel_reg[`ORSB_SRC_AJ:`ORSB_SRC_XJ];
  assign has_k    = |u2_src_sel_reg[`ORSB_SRC_XK:`ORSB_SRC_BK];
  assign mem_use  = (u2_mem_reg != 3'h0);
  assign mem_idx  = {`ORSB_GRP_X, u2_mem_reg};
  assign mem_code = `ORSB_CODE_MEM_BASE | {1'b0, u2_mem_reg};

  ////////////////////////////////////////////////////////////////////////////////
  // first order conflicts and issue
  logic unit_conf;
  logic reg_conf;
  logic issue_now;

  assign unit_conf = u2_valid_reg && (((u2_unit_reg != `ORSB_CODE_NONE) && busy_reg[u2_unit_reg])
                     || (mem_use && busy_reg[mem_code]));
  assign reg_conf  = u2_valid_reg && ((has_res && (result_reservation_list[res_idx] != `ORSB_CODE_NONE))
                     || (mem_use && (result_reservation_list[mem_idx] != `ORSB_CODE_NONE)));
  // second order conflicts never enter here, so issue keeps flowing
  assign issue_now = u2_valid_reg && ctrl_en_reg && !unit_conf && !reg_conf;

  logic u1_take;
  assign u1_take = i_u1_xfer && o_u2_free;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      u2_valid_reg   <= 1'b0;
      u2_unit_reg    <= `ORSB_CODE_NONE;
      u2_mem_reg     <= 3'h0;
      u2_i_reg       <= 3'h0;
      u2_j_reg       <= 3'h0;
      u2_k_reg       <= 3'h0;
      u2_res_sel_reg <= 4'h0;
      u2_src_sel_reg <= 5'h00;
      o_u2_free      <= 1'b1;
      o_issue        <= 1'b0;
    end else begin
      o_issue   <= issue_now;
      o_u2_free <= !(u1_take || (u2_valid_reg && !issue_now));
      if (u1_take) begin
        u2_valid_reg   <= 1'b1;
        u2_unit_reg    <= decode_unit(i_u1_opcode, busy_reg);
        u2_mem_reg     <= ((i_u1_opcode[5:3] == 3'h5) && (i_u1_i != 3'h0) && (i_u1_i <= `ORSB_MEM_CH_MAX))
                          ? i_u1_i : 3'h0;
        u2_i_reg       <= i_u1_i;
        u2_j_reg       <= i_u1_j;
        u2_k_reg       <= i_u1_k;
        u2_res_sel_reg <= i_u1_res_sel;
        u2_src_sel_reg <= i_u1_src_sel;
      end else if (issue_now) begin
        u2_valid_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // third order check and release, lowest code wins a tie
  orsb_uvec_t blocked;
  orsb_uvec_t rel_cand;
  logic       rel_any;
  orsb_code_t rel_code;

  always_comb begin
    blocked  = '0;
    rel_any  = 1'b0;
    rel_code = `ORSB_CODE_NONE;
    for (int c = 0; c < `ORSB_NUM_CODES; c++) begin
      for (int u = 0; u < `ORSB_NUM_CODES; u++) begin
        if (u != c && fi_use_reg[c] &&
            ((rfj_reg[u] && first_source_register_number[u] == result_register_number[c]) ||
             (rfk_reg[u] && second_source_register_number[u] == result_register_number[c])))
          blocked[c] = 1'b1;
      end
    end
    rel_cand = i_release_req & busy_reg & ~blocked;
    for (int c = `ORSB_NUM_CODES - 1; c > 0; c--) begin
      if (rel_cand[c]) begin
        rel_any  = 1'b1;
        rel_code = 4'(c);
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_release   <= '0;
      o_store_en  <= 1'b0;
      o_store_idx <= 5'h00;
    end else begin
      o_release   <= rel_any ? (16'h0001 << rel_code) : 16'h0000;
      o_store_en  <= rel_any && fi_use_reg[rel_code];
      o_store_idx <= result_register_number[rel_code];
    end
  end

  // a slot being released this cycle is already free for a new reader
  function automatic orsb_code_t slot_now(input orsb_ridx_t idx);
    orsb_code_t s;
    s = result_reservation_list[idx];
    if (rel_any && s == rel_code)
      s = `ORSB_CODE_NONE;
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // reservation list and busy flags
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int s = 0; s < `ORSB_NUM_REGS; s++)
        result_reservation_list[s] <= `ORSB_CODE_NONE;
      busy_reg <= '0;
    end else begin
      for (int s = 0; s < `ORSB_NUM_REGS; s++) begin
        if (rel_any && result_reservation_list[s] == rel_code)
          result_reservation_list[s] <= `ORSB_CODE_NONE;
        if (issue_now && has_res && u2_unit_reg != `ORSB_CODE_NONE && 5'(s) == res_idx)
          result_reservation_list[s] <= u2_unit_reg;
        if (issue_now && mem_use && 5'(s) == mem_idx)
          result_reservation_list[s] <= mem_code;
      end
      if (rel_any)
        busy_reg[rel_code] <= 1'b0;
      if (issue_now && u2_unit_reg != `ORSB_CODE_NONE)
        busy_reg[u2_unit_reg] <= 1'b1;
      if (issue_now && mem_use)
        busy_reg[mem_code] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // per-unit designators, read flags and go
  orsb_uvec_t go_now;
  assign go_now = armed_reg & rfj_reg & rfk_reg;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int u = 0; u < `ORSB_NUM_CODES; u++) begin
        first_source_pending_code[u]     <= `ORSB_CODE_NONE;
        second_source_pending_code[u]    <= `ORSB_CODE_NONE;
        result_register_number[u]        <= 5'h00;
        first_source_register_number[u]  <= 5'h00;
        second_source_register_number[u] <= 5'h00;
      end
      fi_use_reg <= '0;
      fj_use_reg <= '0;
      fk_use_reg <= '0;
      armed_reg  <= '0;
      rfj_reg    <= '0;
      rfk_reg    <= '0;
    end else begin
      for (int u = 1; u < `ORSB_NUM_CODES; u++) begin
        if (issue_now && mem_use && 4'(u) == mem_code) begin
          result_register_number[u] <= mem_idx;
          fi_use_reg[u]             <= 1'b1;
        end else if (issue_now && 4'(u) == u2_unit_reg) begin
          first_source_pending_code[u]     <= has_j ? slot_now(srcj_idx) : `ORSB_CODE_NONE;
          second_source_pending_code[u]    <= has_k ? slot_now(srck_idx) : `ORSB_CODE_NONE;
          result_register_number[u]        <= res_idx;
          first_source_register_number[u]  <= srcj_idx;
          second_source_register_number[u] <= srck_idx;
          fi_use_reg[u] <= has_res;
          fj_use_reg[u] <= has_j;
          fk_use_reg[u] <= has_k;
          armed_reg[u]  <= 1'b1;
          rfj_reg[u]    <= 1'b0;
          rfk_reg[u]    <= 1'b0;
        end else if (go_now[u]) begin
          armed_reg[u] <= 1'b0;
          rfj_reg[u]   <= 1'b0;
          rfk_reg[u]   <= 1'b0;
        end else if (armed_reg[u]) begin
          if (first_source_pending_code[u] == `ORSB_CODE_NONE)
            rfj_reg[u] <= 1'b1;
          else if (rel_any && first_source_pending_code[u] == rel_code) begin
            rfj_reg[u] <= 1'b1;
            first_source_pending_code[u] <= `ORSB_CODE_NONE;
          end
          if (second_source_pending_code[u] == `ORSB_CODE_NONE)
            rfk_reg[u] <= 1'b1;
          else if (rel_any && second_source_pending_code[u] == rel_code) begin
            rfk_reg[u] <= 1'b1;
            second_source_pending_code[u] <= `ORSB_CODE_NONE;
          end
        end
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_go         <= '0;
      o_read_j_en  <= '0;
      o_read_k_en  <= '0;
      o_read_j_idx <= '0;
      o_read_k_idx <= '0;
    end else begin
      o_go        <= go_now;
      o_read_j_en <= go_now & fj_use_reg;
      o_read_k_en <= go_now & fk_use_reg;
      for (int u = 0; u < `ORSB_NUM_CODES; u++) begin
        o_read_j_idx[u] <= first_source_register_number[u];
        o_read_k_idx[u] <= second_source_register_number[u];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states; data prepared in the setup cycle
  logic        setup;
  logic        wr_acc;
  logic [31:0] rd_val;
  logic        rd_err;

  assign setup  = i_psel && !i_penable;
  assign wr_acc = i_psel && i_penable && o_pready && i_pwrite;

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_err = 1'b0;
    unique case (i_paddr)
      `ORSB_OFS_CTRL:      rd_val = {31'h0000_0000, ctrl_en_reg};
      `ORSB_OFS_STATUS:    rd_val = {13'h0000, u2_valid_reg, reg_conf, unit_conf, busy_reg};
      `ORSB_OFS_SLOT_SEL:  rd_val = {27'h000_0000, slot_sel_reg};
      `ORSB_OFS_SLOT_CODE: rd_val = (slot_sel_reg < 5'(`ORSB_NUM_REGS))
                                    ? {28'h000_0000, result_reservation_list[slot_sel_reg]} : 32'h0000_0000;
      default:             rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= setup;
      o_pslverr <= setup && rd_err;
      o_prdata  <= (setup && !i_pwrite) ? rd_val : 32'h0000_0000;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_en_reg  <= `ORSB_CTRL_RST;
      slot_sel_reg <= 5'h00;
    end else if (wr_acc) begin
      if (i_paddr == `ORSB_OFS_CTRL)
        ctrl_en_reg <= i_pwdata[0];
      if (i_paddr == `ORSB_OFS_SLOT_SEL)
        slot_sel_reg <= i_pwdata[4:0];
    end
  end

endmodule // orsb_scoreboard

`default_nettype wire

// *** orsb_consts.svh ***
`ifndef ORSB_CONSTS_SVH
`define ORSB_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// unit reservation codes (octal 01..07, 11..15, 16, 17)
`define ORSB_NUM_CODES        16
`define ORSB_NUM_REGS         24
`define ORSB_CODE_NONE        4'h0
`define ORSB_CODE_INC1        4'h1
`define ORSB_CODE_INC2        4'h2
`define ORSB_CODE_SHIFT       4'h3
`define ORSB_CODE_BOOL        4'h4
`define ORSB_CODE_DIV         4'h5
`define ORSB_CODE_MUL1        4'h6
`define ORSB_CODE_MUL2        4'h7
`define ORSB_CODE_MEM_BASE    4'h8
`define ORSB_CODE_LADD        4'hE
`define ORSB_CODE_ADD         4'hF
`define ORSB_MEM_CH_MAX       3'h5

////////////////////////////////////////////////////////////////////////////////
// register groups: slot index is {group, number}
`define ORSB_GRP_X            2'h0
`define ORSB_GRP_B            2'h1
`define ORSB_GRP_A            2'h2

// result select bits: Xi, Bi, Ai, Bj
`define ORSB_RES_XI           0
`define ORSB_RES_BI           1
`define ORSB_RES_AI           2
`define ORSB_RES_BJ           3
// source select bits: Xj, Bj, Aj, Bk, Xk
`define ORSB_SRC_XJ           0
`define ORSB_SRC_BJ           1
`define ORSB_SRC_AJ           2
`define ORSB_SRC_BK           3
`define ORSB_SRC_XK           4

////////////////////////////////////////////////////////////////////////////////
// apb register map
`define ORSB_OFS_CTRL         12'h000
`define ORSB_OFS_STATUS       12'h004
`define ORSB_OFS_SLOT_SEL     12'h008
`define ORSB_OFS_SLOT_CODE    12'h00C
`define ORSB_CTRL_RST         1'h1
`define ORSB_STAT_UCONF_BIT   16
`define ORSB_STAT_RCONF_BIT   17
`define ORSB_STAT_U2V_BIT     18

`endif

// *** orsb_pkg.sv ***
`default_nettype none

package orsb_pkg;
  typedef logic [3:0]        orsb_code_t;
  typedef logic [2:0]        orsb_num_t;
  typedef logic [4:0]        orsb_ridx_t;
  typedef logic [15:0]       orsb_uvec_t;
  typedef logic [15:0][4:0]  orsb_uidx_t;
endpackage : orsb_pkg

`default_nettype wire

// *** orsb_scoreboard_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module orsb_scoreboard_asserts
  import orsb_pkg::*;
(
  input wire logic       i_clk,          // minor cycle clock
  input wire logic       i_sys_rst,      // async reset
  input wire logic       i_u1_xfer,      // stage move
  input wire orsb_uvec_t i_release_req,  // release requests
  input wire logic       o_u2_free,      // second stage free
  input wire logic       o_issue,        // issue pulse
  input wire orsb_uvec_t o_go,           // go pulses
  input wire orsb_uvec_t o_read_j_en,    // read command, j
  input wire orsb_uvec_t o_release,      // release pulses
  input wire logic       o_store_en      // go store
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  property p_take; i_u1_xfer && o_u2_free |=> !o_u2_free; endproperty
  a_take: assert property (p_take) else $error("stage move not taken");
  property p_issue_gap; o_issue |=> !o_issue; endproperty
  a_issue_gap: assert property (p_issue_gap) else $error("issue pulses too close");
  // a stall may last a long calculation, so the bound is generous
  property p_xfer_issue; i_u1_xfer && o_u2_free |-> ##[2:200] o_issue; endproperty
  a_xfer_issue: assert property (p_xfer_issue) else $error("issue never came");
  property p_go_pulse; (o_go & $past(o_go)) == '0; endproperty
  a_go_pulse: assert property (p_go_pulse) else $error("go held two cycles");
  property p_read_go; (o_read_j_en & ~o_go) == '0; endproperty
  a_read_go: assert property (p_read_go) else $error("read command without go");
  property p_rel_one; $onehot0(o_release); endproperty
  a_rel_one: assert property (p_rel_one) else $error("two releases at once");
  property p_rel_req; (o_release & ~$past(i_release_req)) == '0; endproperty
  a_rel_req: assert property (p_rel_req) else $error("release without request");
  property p_store_rel; o_store_en |-> (o_release != '0); endproperty
  a_store_rel: assert property (p_store_rel) else $error("store without release");
  c_add_go: cover property (o_go[15]);
  c_store: cover property (o_store_en);
  c_stall: cover property (!o_u2_free [*8]);
endmodule // orsb_scoreboard_asserts
`default_nettype wire

// *** orsb_fu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module orsb_fu_model
  import orsb_pkg::*;
(
  input  wire logic       i_clk,          // minor cycle clock
  input  wire logic       i_sys_rst,      // async reset
  input  wire orsb_uvec_t i_go,           // start calculation
  input  wire orsb_uvec_t i_release,      // store granted
  input  wire logic [5:0] i_delay,        // calculation time
  output var  orsb_uvec_t o_release_req   // store wanted
);
  logic [15:0][6:0] cnt_reg;
  orsb_uvec_t       run_reg;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_reg <= '0;
      run_reg <= '0;
      o_release_req <= '0;
    end else begin
      for (int u = 0; u < 16; u++) begin
        if (i_go[u]) begin
          run_reg[u] <= 1'b1;
          // divide runs long so a later unit can finish first
          cnt_reg[u] <= (u == 5) ? 7'h3C : {1'b0, i_delay};
        end else if (run_reg[u] && cnt_reg[u] != 7'h00) begin
          cnt_reg[u] <= cnt_reg[u] - 7'h01;
        end else if (run_reg[u]) begin
          o_release_req[u] <= 1'b1;
          run_reg[u] <= 1'b0;
        end
        if (i_release[u]) begin
          o_release_req[u] <= 1'b0;
        end
      end
    end
  end
endmodule // orsb_fu_model
`default_nettype wire

// *** orsb_scoreboard_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module orsb_scoreboard_test;
  import orsb_pkg::*;
  logic        i_clk, i_sys_rst, psel, penable, pwrite, xfer, pready, pslverr, u2_free, issue, store_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [5:0]  op, dly;
  orsb_num_t   ii, jj, kk;
  orsb_uvec_t  rreq, go, rj, rk, rel;
  orsb_uidx_t  jidx, kidx;
  orsb_ridx_t  sidx;
  int          num_errors, checks;
  integer      seed = 32'hE9A3E280;
  logic [32:0] aq[$];
  logic [14:0] eq[$];
  orsb_scoreboard u_orsb_scoreboard (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .i_u1_xfer(xfer), .i_u1_opcode(op), .i_u1_i(ii), .i_u1_j(jj), .i_u1_k(kk),
    .i_u1_res_sel(4'h1), .i_u1_src_sel(5'h11), .o_u2_free(u2_free), .o_issue(issue), .i_release_req(rreq),
    .o_go(go), .o_read_j_en(rj), .o_read_k_en(rk), .o_read_j_idx(jidx), .o_read_k_idx(kidx),
    .o_release(rel), .o_store_en(store_en), .o_store_idx(sidx));
  orsb_fu_model u_orsb_fu_model (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_go(go), .i_release(rel),
    .i_delay(dly), .o_release_req(rreq));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [14:0] ev(input logic r, input logic [3:0] c, input logic [4:0] a, b);
    return {r, c, a, b};
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    n = 0;
    do @(posedge i_clk); while (pready !== 1'b1 && n++ < 50);
    if (pready !== 1'b1) num_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] exp);
    aq.push_back(exp);
    apb(1'b0, a, 32'h0);
  endtask
  // every instruction reads Xj, Xk and writes Xi
  task automatic ins(input logic [5:0] o, input orsb_num_t i, j, k, input logic w);
    int n;
    n = 0;
    do @(posedge i_clk); while (u2_free !== 1'b1 && n++ < 200);
    if (u2_free !== 1'b1) num_errors++;
    xfer <= 1'b1;
    op <= o;
    ii <= i;
    jj <= j;
    kk <= k;
    @(posedge i_clk);
    xfer <= 1'b0;
    n = 0;
    while (w && issue !== 1'b1 && n++ < 200) @(posedge i_clk);
    if (w && issue !== 1'b1) num_errors++;
  endtask
  task automatic drain(input string name);
    int n;
    n = 0;
    while (eq.size() != 0 && n++ < 400) @(posedge i_clk);
    chk(33'(eq.size()), 33'h0);
    $display("test %s done", name);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  initial begin
    forever begin
      @(posedge i_clk);
      if (pready === 1'b1 && pwrite === 1'b0) chk({pslverr, prdata}, aq.pop_front());
      for (int u = 0; u < 16; u++) begin
        if (go[u] === 1'b1) begin
          chk({1'b0, u[3:0], jidx[u], kidx[u]}, eq.pop_front());
          chk({rj[u], rk[u]}, 33'h3);
        end
        if (rel[u] === 1'b1) chk({1'b1, u[3:0], store_en ? sidx : 5'h1F, 5'h00}, eq.pop_front());
      end
    end
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    num_errors++;
    summarize();
  end
  initial begin
    {i_sys_rst, psel, penable, pwrite, xfer, paddr, pwdata, op, ii, jj, kk} = '0;
    i_sys_rst = 1'b1;
    dly = 6'h0A + 6'($random(seed) & 3);
    repeat (16) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd(12'h000, 33'h1);
    rd(12'h004, 33'h0);
    rd(12'h010, 33'h1_0000_0000);
    // any index past the last slot reads as free
    apb(1'b1, 12'h008, 32'h18 + 32'($random(seed) & 7));
    rd(12'h00C, 33'h0);
    $display("test reset done");
    // later issue and start go on while the multiply waits for its source
    eq = {eq, ev(0, 4, 2, 3), ev(0, 5, 2, 3), ev(1, 4, 1, 0), ev(0, 6, 3, 1), ev(1, 6, 5, 0)};
    eq = {eq, ev(0, 15, 2, 5), ev(1, 15, 6, 0), ev(1, 5, 0, 0)};
    ins(6'h08, 1, 2, 3, 1'b1);
    ins(6'h20, 5, 3, 1, 1'b1);
    ins(6'h24, 0, 2, 3, 1'b1);
    ins(6'h18, 6, 2, 5, 1'b1);
    drain("second_order");
    // add must not store into X4 before the multiply has read it
    eq = {eq, ev(0, 5, 1, 2), ev(0, 15, 0, 6), ev(1, 5, 3, 0), ev(0, 6, 4, 3), ev(1, 15, 4, 0), ev(1, 6, 5, 0)};
    ins(6'h24, 3, 1, 2, 1'b1);
    ins(6'h20, 5, 4, 3, 1'b1);
    ins(6'h18, 4, 0, 6, 1'b1);
    apb(1'b1, 12'h008, 32'h4);
    rd(12'h00C, 33'hF);
    drain("third_order");
    eq = {eq, ev(0, 4, 2, 3), ev(1, 4, 1, 0), ev(0, 6, 2, 3), ev(1, 6, 1, 0)};
    apb(1'b1, 12'h000, 32'h0);
    ins(6'h08, 1, 2, 3, 1'b0);
    rd(12'h004, 33'h0004_0000);
    apb(1'b1, 12'h000, 32'h1);
    ins(6'h20, 1, 2, 3, 1'b0);
    rd(12'h004, 33'h0006_0010);
    apb(1'b1, 12'h008, 32'h1);
    rd(12'h00C, 33'h4);
    drain("first_order");
    summarize();
  end
endmodule // orsb_scoreboard_test
bind orsb_scoreboard orsb_scoreboard_asserts u_orsb_scoreboard_asserts (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_u1_xfer(i_u1_xfer), .i_release_req(i_release_req), .o_u2_free(o_u2_free), .o_issue(o_issue),
  .o_go(o_go), .o_read_j_en(o_read_j_en), .o_release(o_release), .o_store_en(o_store_en));
`default_nettype wire
